// file: src/timer_pin_b_io_select.sv
// Pin B role selection for channels 4 and 5 behind an AHB-Lite slave
//
// Notes on behaviour
// R01: Output compare, low bits 01: pin goes 0 on match; bit 2 initial level.
// R02: Output compare, low bits 10: pin goes 1 on match, from initial level.
// R03: Output compare, low bits 11 toggles on match; low bits 00 disable.
// R04: Top bit 1, low bits 00: capture on rising pin edge.
// R05: Capture mode, low bits 01: capture on falling pin edge.
// R06: Capture mode, bit 1 set: capture on both edges, bit 0 ignored.
// R07: Channel 4, top two bits set: capture on channel 3 C event.
// R08: Each capture copies the counter into the B register that cycle.
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`include "timer_pin_b_regs.svh"
module timer_pin_b_io_select (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic [31:0] HRDATA,
   output logic HRESP,
   // Counters of channels 4 and 5
   input wire timer_pin_b_pkg::count_t CNT4,
   input wire timer_pin_b_pkg::count_t CNT5,
   // Channel 3 C register event, one-cycle pulse
   input wire logic C3_EVENT,
   // Channel 4 pin B
   input wire logic PIN_B4_I,
   output logic PIN_B4_O,
   output logic PIN_B4_OE,
   // Channel 5 pin B
   input wire logic PIN_B5_I,
   output logic PIN_B5_O,
   output logic PIN_B5_OE,
   // Capture pulses
   output logic CAPT4,
   output logic CAPT5
);

   // ----------------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------------
   timer_pin_b_pkg::ctrl_t ctrl_q [2];
   logic [1:0] load_q;
   logic [1:0] genb_wr;
   logic [`ADDR_W-1:0] addr_q;
   logic wr_q;
   logic accept;
   logic [31:0] rd_val;
   logic [31:0] rdata_q;
   logic hreadyout_q;
   logic hresp_q;

   // Per-channel wires
   timer_pin_b_pkg::count_t cnt [2];
   timer_pin_b_pkg::count_t genb [2];
   timer_pin_b_pkg::pin_mode_t mode [2];
   logic [1:0] pin_i;
   logic [1:0] pin_o;
   logic [1:0] pin_oe;
   logic [1:0] capt;
   logic [1:0] lvl;
   logic [1:0] rise;
   logic [1:0] fall;
   logic [1:0] hit;
   logic [1:0] hit_q;
   logic [1:0] match;

   assign cnt[0] = CNT4;
   assign cnt[1] = CNT5;
   assign pin_i = {PIN_B5_I, PIN_B4_I};

   // Address phase is taken only when the bus is ready
   assign accept = HSEL && HTRANS[`HTRANS_ACT] && HREADY;

   // Read mux, evaluated in the address phase
   always_comb begin
      rd_val = 32'h0000_0000;
      if (HADDR[`ADDR_W-1:0] == `OFS_C4_CTRL) begin
         rd_val = {24'h00_0000, ctrl_q[0]};
      end else if (HADDR[`ADDR_W-1:0] == `OFS_C5_CTRL) begin
         rd_val = {24'h00_0000, ctrl_q[1]};
      end else if (HADDR[`ADDR_W-1:0] == `OFS_C4_GENB) begin
         rd_val = {16'h0000, genb[0]};
      end else if (HADDR[`ADDR_W-1:0] == `OFS_C5_GENB) begin
         rd_val = {16'h0000, genb[1]};
      end else if (HADDR[`ADDR_W-1:0] == `OFS_STATUS) begin
         rd_val = {28'h000_0000, pin_oe, lvl};
      end
   end

   // Address phase capture; sub-word writes are dropped without error
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         addr_q <= `ADDR_W'(0);
         wr_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         wr_q <= accept && HWRITE && (HSIZE == `HSIZE_WORD);
         if (accept) begin
            addr_q <= HADDR[`ADDR_W-1:0];
         end
         rdata_q <= (accept && !HWRITE) ? rd_val : 32'h0000_0000;
      end
   end

   // Zero wait state slave, always OKAY
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   // Control registers; load pulse follows so the new setting is seen
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_q[0] <= `CTRL_RST;
         ctrl_q[1] <= `CTRL_RST;
         load_q <= 2'h0;
      end else begin
         load_q <= 2'h0;
         if (wr_q && addr_q == `OFS_C4_CTRL) begin
            ctrl_q[0] <= HWDATA[`CTRL_W-1:0];
            load_q[0] <= 1'b1;
         end else if (wr_q && addr_q == `OFS_C5_CTRL) begin
            ctrl_q[1] <= HWDATA[`CTRL_W-1:0];
            load_q[1] <= 1'b1;
         end
      end
   end

   // B register write strobes, data phase
   assign genb_wr[0] = wr_q && (addr_q == `OFS_C4_GENB);
   assign genb_wr[1] = wr_q && (addr_q == `OFS_C5_GENB);

   // Equality seen last cycle; one process keeps the vector single-driven
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         hit_q <= 2'h0;
      end else begin
         hit_q <= hit;
      end
   end

   // ----------------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_ch
         // A match is the first cycle the counter equals the B register,
         // so a stopped counter does not toggle the pin every cycle
         assign hit[i] = (cnt[i] == genb[i]);
         assign match[i] = hit[i] & ~hit_q[i];

         pin_b_sync u_sync (
            .clk(CLK),
            .rst_n(RST_N),
            .pin_i(pin_i[i]),
            .level(lvl[i]),
            .rise(rise[i]),
            .fall(fall[i])
         );

         pin_b_channel #(
            .C3_SRC(i == 0)
         ) u_chan (
            .clk(CLK),
            .rst_n(RST_N),
            .sel(ctrl_q[i][`SEL_MSB:`SEL_LSB]),
            .sel_load(load_q[i]),
            .genb_wr(genb_wr[i]),
            .genb_wdata(HWDATA[`CNT_W-1:0]),
            .cnt(cnt[i]),
            .match(match[i]),
            .rise(rise[i]),
            .fall(fall[i]),
            .c3_evt((i == 0) ? C3_EVENT : 1'b0),
            .mode(mode[i]),
            .genb_q(genb[i]),
            .pin_o_q(pin_o[i]),
            .pin_oe_q(pin_oe[i]),
            .capt_q(capt[i])
         );

         // -------------------------------------------------------------
         // Checks per channel
         // -------------------------------------------------------------
         property p_oc_low;
            @(posedge CLK) disable iff (!RST_N)
            match[i] && !load_q[i] && mode[i] == timer_pin_b_pkg::OC_LOW
               |=> pin_o[i] == 1'b0;
         endproperty
         a_oc_low: assert property (p_oc_low) // [R01]
            else $error("pin not low after match");

         property p_oc_high;
            @(posedge CLK) disable iff (!RST_N)
            match[i] && !load_q[i] && mode[i] == timer_pin_b_pkg::OC_HIGH
               |=> pin_o[i] == 1'b1 && pin_oe[i];
         endproperty
         a_oc_high: assert property (p_oc_high) // [R02]
            else $error("pin not high after match");

         property p_oc_tog;
            @(posedge CLK) disable iff (!RST_N)
            match[i] && !load_q[i] && mode[i] == timer_pin_b_pkg::OC_TOGGLE
               |=> pin_o[i] != $past(pin_o[i]);
         endproperty
         a_oc_tog: assert property (p_oc_tog) // [R03]
            else $error("pin did not toggle");

         property p_off;
            @(posedge CLK) disable iff (!RST_N)
            mode[i] == timer_pin_b_pkg::MODE_OFF [*2] |-> !pin_oe[i];
         endproperty
         a_off: assert property (p_off) // [R03]
            else $error("pin driven while disabled");

         property p_init;
            @(posedge CLK) disable iff (!RST_N)
            load_q[i] && !ctrl_q[i][`SEL_MSB] &&
               ctrl_q[i][`SEL_LSB+`SELB1 -: 2] != 2'h0
               |=> pin_o[i] == $past(ctrl_q[i][`SEL_LSB+`SELB2]);
         endproperty
         a_init: assert property (p_init) // [R01]
            else $error("initial level wrong");

         property p_rise;
            @(posedge CLK) disable iff (!RST_N)
            mode[i] == timer_pin_b_pkg::IC_RISE && rise[i]
               |=> genb[i] == $past(cnt[i]) && capt[i];
         endproperty
         a_rise: assert property (p_rise) // [R04]
            else $error("rising edge not captured");

         property p_fall;
            @(posedge CLK) disable iff (!RST_N)
            mode[i] == timer_pin_b_pkg::IC_FALL && fall[i]
               |=> genb[i] == $past(cnt[i]);
         endproperty
         a_fall: assert property (p_fall) // [R05]
            else $error("falling edge not captured");

         property p_fall_only;
            @(posedge CLK) disable iff (!RST_N)
            mode[i] == timer_pin_b_pkg::IC_FALL && rise[i] && !genb_wr[i]
               |=> $stable(genb[i]) && !capt[i];
         endproperty
         a_fall_only: assert property (p_fall_only) // [R05]
            else $error("rising edge captured in falling mode");

         property p_both;
            @(posedge CLK) disable iff (!RST_N)
            mode[i] == timer_pin_b_pkg::IC_BOTH && (rise[i] || fall[i])
               |=> genb[i] == $past(cnt[i]);
         endproperty
         a_both: assert property (p_both) // [R06]
            else $error("edge missed in both-edge mode");

         property p_capt;
            @(posedge CLK) disable iff (!RST_N)
            capt[i] |-> genb[i] == $past(cnt[i]);
         endproperty
         a_capt: assert property (p_capt) // [R08]
            else $error("capture did not copy counter");
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Checks on channel 4 source selection and the bus
   // ----------------------------------------------------------------------
   property p_c3;
      @(posedge CLK) disable iff (!RST_N)
      mode[0] == timer_pin_b_pkg::IC_C3 && C3_EVENT
         |=> genb[0] == $past(CNT4) && CAPT4;
   endproperty
   a_c3: assert property (p_c3) // [R07]
      else $error("channel 3 event not captured");

   property p_c3_no_pin;
      @(posedge CLK) disable iff (!RST_N)
      mode[0] == timer_pin_b_pkg::IC_C3 && !C3_EVENT && !genb_wr[0]
         |=> $stable(genb[0]);
   endproperty
   a_c3_no_pin: assert property (p_c3_no_pin) // [R07]
      else $error("pin edge captured with channel 3 source");

   property p_rd_ctrl4;
      @(posedge CLK) disable iff (!RST_N)
      accept && !HWRITE && HADDR[`ADDR_W-1:0] == `OFS_C4_CTRL && !wr_q
         |=> HRDATA == {24'h00_0000, ctrl_q[0]} && HREADYOUT;
   endproperty
   a_rd_ctrl4: assert property (p_rd_ctrl4)
      else $error("control read data wrong");

   // Main scenarios
   c_toggle: cover property (@(posedge CLK) disable iff (!RST_N)
      match[0] && mode[0] == timer_pin_b_pkg::OC_TOGGLE);
   c_c3: cover property (@(posedge CLK) disable iff (!RST_N)
      mode[0] == timer_pin_b_pkg::IC_C3 && C3_EVENT);
   c_both: cover property (@(posedge CLK) disable iff (!RST_N)
      mode[1] == timer_pin_b_pkg::IC_BOTH && fall[1]);
   c_race: cover property (@(posedge CLK) disable iff (!RST_N)
      capt[1] && $past(genb_wr[1]));

   // ----------------------------------------------------------------------
   // Outputs, each straight from a flop
   // ----------------------------------------------------------------------
   assign HREADYOUT = hreadyout_q;
   assign HRDATA = rdata_q;
   assign HRESP = hresp_q;
   assign PIN_B4_O = pin_o[0];
   assign PIN_B4_OE = pin_oe[0];
   assign PIN_B5_O = pin_o[1];
   assign PIN_B5_OE = pin_oe[1];
   assign CAPT4 = capt[0];
   assign CAPT5 = capt[1];

endmodule

// file: src/timer_pin_b_regs.svh
// Register offsets, field positions, reset values and widths for pin B select
`ifndef TIMER_PIN_B_REGS_SVH
`define TIMER_PIN_B_REGS_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define CNT_W 16
`define CTRL_W 8
`define ADDR_W 8

// ----------------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------------
`define OFS_C4_CTRL 8'h00
`define OFS_C5_CTRL 8'h04
`define OFS_C4_GENB 8'h08
`define OFS_C5_GENB 8'h0C
`define OFS_STATUS 8'h10

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CTRL_RST 8'h00
`define GENB_RST 16'hFFFF

// ----------------------------------------------------------------------
// Selector field inside the control register, and bits within it
// ----------------------------------------------------------------------
`define SEL_MSB 7
`define SEL_LSB 4
`define SELB3 3
`define SELB2 2
`define SELB1 1
`define SELB0 0

// ----------------------------------------------------------------------
// Bus encodings
// ----------------------------------------------------------------------
`define HTRANS_ACT 1
`define HSIZE_WORD 3'h2

`endif

// file: src/timer_pin_b_pkg.sv
// Types shared by the pin B selection logic
`include "timer_pin_b_regs.svh"

package timer_pin_b_pkg;

   // -------------------------------------------------------------------
   // Pin roles decoded from the selector field
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_OFF  = 3'b000,
      OC_LOW    = 3'b001,
      OC_HIGH   = 3'b010,
      OC_TOGGLE = 3'b011,
      IC_RISE   = 3'b100,
      IC_FALL   = 3'b101,
      IC_BOTH   = 3'b110,
      IC_C3     = 3'b111
   } pin_mode_t;

   typedef logic [`CNT_W-1:0] count_t;
   typedef logic [`CTRL_W-1:0] ctrl_t;

endpackage

// file: src/pin_b_sync.sv
// Two-flop synchroniser and edge detector for one timer pin
module pin_b_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pin
   input wire logic pin_i,
   // Synchronised level and edge pulses
   output logic level,
   output logic rise,
   output logic fall
);

   logic s1_q;
   logic s2_q;
   logic s3_q;

   // Only s2 reads s1; edges are taken between s2 and s3
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Edge pulses, one cycle each
   assign level = s2_q;
   assign rise = s2_q & ~s3_q;
   assign fall = ~s2_q & s3_q;

endmodule

// file: src/pin_b_channel.sv
// Mode decode, pin drive and B register capture for one channel
`include "timer_pin_b_regs.svh"
module pin_b_channel #(
   parameter bit C3_SRC = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Configuration
   input wire logic [3:0] sel,
   input wire logic sel_load,
   // Software access to the B register
   input wire logic genb_wr,
   input wire timer_pin_b_pkg::count_t genb_wdata,
   // Timer events
   input wire timer_pin_b_pkg::count_t cnt,
   input wire logic match,
   input wire logic rise,
   input wire logic fall,
   input wire logic c3_evt,
   // Results
   output timer_pin_b_pkg::pin_mode_t mode,
   output timer_pin_b_pkg::count_t genb_q,
   output logic pin_o_q,
   output logic pin_oe_q,
   output logic capt_q
);

   logic is_oc;
   logic ev;

   // Selector decode; the c3 source only exists where C3_SRC is set
   always_comb begin
      mode = timer_pin_b_pkg::MODE_OFF;
      if (!sel[`SELB3]) begin
         case (sel[`SELB1:`SELB0])
            2'h1: mode = timer_pin_b_pkg::OC_LOW;
            2'h2: mode = timer_pin_b_pkg::OC_HIGH;
            2'h3: mode = timer_pin_b_pkg::OC_TOGGLE;
            default: mode = timer_pin_b_pkg::MODE_OFF;
         endcase
      end else if (C3_SRC && sel[`SELB2]) begin
         mode = timer_pin_b_pkg::IC_C3; // [R07]
      end else if (sel[`SELB1]) begin
         mode = timer_pin_b_pkg::IC_BOTH; // [R06]
      end else if (sel[`SELB0]) begin
         mode = timer_pin_b_pkg::IC_FALL; // [R05]
      end else begin
         mode = timer_pin_b_pkg::IC_RISE; // [R04]
      end
   end

   assign is_oc = !sel[`SELB3] && (sel[`SELB1:`SELB0] != 2'h0);

   // Capture source per mode
   always_comb begin
      case (mode)
         timer_pin_b_pkg::IC_RISE: ev = rise; // [R04]
         timer_pin_b_pkg::IC_FALL: ev = fall; // [R05]
         timer_pin_b_pkg::IC_BOTH: ev = rise | fall; // [R06]
         timer_pin_b_pkg::IC_C3: ev = c3_evt; // [R07]
         default: ev = 1'b0;
      endcase
   end

   // B register: a capture beats a software write in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         genb_q <= `GENB_RST;
         capt_q <= 1'b0;
      end else begin
         capt_q <= ev;
         if (ev) begin
            genb_q <= cnt; // [R08]
         end else if (genb_wr) begin
            genb_q <= genb_wdata;
         end
      end
   end

   // Pin drive: a new setting loads the initial level, then matches act
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_o_q <= 1'b0;
         pin_oe_q <= 1'b0;
      end else begin
         pin_oe_q <= is_oc; // [R03]
         if (sel_load) begin
            pin_o_q <= is_oc & sel[`SELB2]; // [R01] [R02] [R03]
         end else if (match && is_oc) begin
            case (mode)
               timer_pin_b_pkg::OC_LOW: pin_o_q <= 1'b0; // [R01]
               timer_pin_b_pkg::OC_HIGH: pin_o_q <= 1'b1; // [R02]
               default: pin_o_q <= ~pin_o_q; // [R03]
            endcase
         end
      end
   end

endmodule

// file: test/pin_partner.sv
// Model of the outside circuit that stands on one pin B
module pin_partner (
   // Device side of the pin
   input wire logic dev_o,
   input wire logic dev_oe,
   // Level the outside circuit drives while the device is off the pin
   input wire logic ext_lvl,
   // Resolved wire level, fed back to the device input
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;

   // Device drive wins; the outside driver is strong, so no floating wire
   always_comb begin
      pin = dev_oe ? dev_o : ext_lvl;
   end
endmodule

// file: test/testbench.sv
// Self-checking bench for the pin B role selection block
`include "timer_pin_b_regs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk, rst_n, hsel, hwrite, c3_evt, lvl4, lvl5, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   timer_pin_b_pkg::count_t cnt4, cnt5;
   logic pin4, pin5, o4, oe4, o5, oe5, capt4, capt5;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;

   // ----------------------------------------------------------------
   // Design and outside circuits
   // ----------------------------------------------------------------
   timer_pin_b_io_select u_timer_pin_b_io_select (.CLK(clk),
      .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
      .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp), .CNT4(cnt4),
      .CNT5(cnt5), .C3_EVENT(c3_evt), .PIN_B4_I(pin4), .PIN_B4_O(o4),
      .PIN_B4_OE(oe4), .PIN_B5_I(pin5), .PIN_B5_O(o5), .PIN_B5_OE(oe5),
      .CAPT4(capt4), .CAPT5(capt5));
   // Two pins, so the instance names carry the channel
   pin_partner u_pin_partner4 (.dev_o(o4), .dev_oe(oe4), .ext_lvl(lvl4),
      .pin(pin4));
   pin_partner u_pin_partner5 (.dev_o(o5), .dev_oe(oe5), .ext_lvl(lvl5),
      .pin(pin5));

   // Clock, 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard, well above the roughly 630 cycles the run needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish;
      end
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // One single transfer; entered just after a rising edge
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      hsize <= `HSIZE_WORD;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h00000000, x);
      cmp32(x, exp);
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic set_cnt(input int ch, input logic [15:0] v);
      if (ch == 1) cnt5 <= v;
      else cnt4 <= v;
   endtask

   task automatic set_lvl(input int ch, input logic v);
      if (ch == 1) lvl5 <= v;
      else lvl4 <= v;
   endtask

   // Counter at the B value for two cycles: one equality rising
   task automatic match(input int ch);
      set_cnt(ch, 16'h0100);
      wait_n(2);
      set_cnt(ch, 16'h0000);
      wait_n(3);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      chk_rd(`OFS_C4_CTRL, 32'h00000000);
      chk_rd(`OFS_C5_CTRL, 32'h00000000);
      chk_rd(`OFS_C4_GENB, 32'h0000FFFF);
      chk_rd(`OFS_C5_GENB, 32'h0000FFFF);
      chk_rd(`OFS_STATUS, 32'h00000000);
      wr(8'h14, 32'hFFFFFFFF);
      chk_rd(8'h14, 32'h00000000);
      cmp1(hresp, 1'b0);
      cmp1(hready, 1'b1);
   endtask

   // Every output code on both channels; toggle gets two matches
   task automatic t_compare;
      logic [3:0] s;
      logic [7:0] ctl, gb;
      for (int ch = 0; ch < 2; ch++) begin
         ctl = ch ? `OFS_C5_CTRL : `OFS_C4_CTRL;
         gb = ch ? `OFS_C5_GENB : `OFS_C4_GENB;
         for (int k = 0; k < 8; k++) begin
            s = k[3:0];
            set_cnt(ch, 16'h0000);
            wr(ctl, {24'h000000, s, 4'h0});
            wr(gb, 32'h00000100);
            wait_n(4);
            cmp1(ch ? oe5 : oe4, s[1:0] != 2'b00);
            if (s[1:0] != 2'b00) begin
               cmp1(ch ? o5 : o4, s[2]);
               // Status: OE and synced level of both pins
               if (k == 7) chk_rd(`OFS_STATUS, ch ? 32'h0000000F : 32'h00000005);
               match(ch);
               if (s[1:0] == 2'b01) cmp1(ch ? o5 : o4, 1'b0);
               if (s[1:0] == 2'b10) cmp1(ch ? o5 : o4, 1'b1);
               if (s[1:0] == 2'b11) cmp1(ch ? o5 : o4, ~s[2]);
               match(ch);
               if (s[1:0] == 2'b11) cmp1(ch ? o5 : o4, s[2]);
            end
         end
      end
   endtask

   // Pin edge captures; channel 5 also with the ignored bit 6 set
   task automatic t_capture;
      logic [3:0] s;
      logic [7:0] ctl, gb;
      logic r, f;
      for (int ch = 0; ch < 2; ch++) begin
         ctl = ch ? `OFS_C5_CTRL : `OFS_C4_CTRL;
         gb = ch ? `OFS_C5_GENB : `OFS_C4_GENB;
         for (int k = 0; k < 5; k++) begin
            if (k < 4 || ch == 1) begin
               s = (k == 4) ? 4'b1100 : (4'b1000 | k[3:0]);
               r = s[1] | ~s[0];
               f = s[1] | s[0];
               set_lvl(ch, 1'b0);
               set_cnt(ch, 16'h1234);
               wr(ctl, {24'h000000, s, 4'h0});
               // Let the mode change settle before clearing B
               wait_n(6);
               wr(gb, 32'h00000000);
               wait_n(2);
               cmp1(ch ? oe5 : oe4, 1'b0);
               set_lvl(ch, 1'b1);
               // Capture pulse stands in the cycle after the third edge
               wait_n(3);
               @(negedge clk);
               cmp1(ch ? capt5 : capt4, r);
               wait_n(3);
               chk_rd(gb, r ? 32'h1234 : 32'h0);
               set_cnt(ch, 16'hABCD);
               set_lvl(ch, 1'b0);
               wait_n(6);
               chk_rd(gb, f ? 32'hABCD : (r ? 32'h1234 : 32'h0));
            end
         end
      end
   endtask

   // Channel 4 takes channel 3 events and ignores its own pin
   task automatic t_c3;
      for (int j = 0; j < 4; j++) begin
         set_lvl(0, 1'b0);
         set_cnt(0, 16'h1111);
         wr(`OFS_C4_CTRL, {24'h000000, 2'b11, j[1:0], 4'h0});
         wait_n(6);
         wr(`OFS_C4_GENB, 32'h00000000);
         wait_n(2);
         set_lvl(0, 1'b1);
         wait_n(6);
         chk_rd(`OFS_C4_GENB, 32'h00000000);
         set_cnt(0, 16'h2222);
         c3_evt <= 1'b1;
         @(posedge clk);
         c3_evt <= 1'b0;
         // Look mid-cycle, where the one-cycle pulse has settled
         @(negedge clk);
         cmp1(capt4, 1'b1);
         @(posedge clk);
         chk_rd(`OFS_C4_GENB, 32'h00002222);
      end
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      c3_evt = 1'b0;
      lvl4 = 1'b0;
      lvl5 = 1'b0;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      htrans = 2'b00;
      hsize = 3'h2;
      cnt4 = 16'h0000;
      cnt5 = 16'h0000;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_compare;
      t_capture;
      t_c3;
      tally_and_finish;
   end
endmodule
